// ---- design/dops_top.v ----
// Control of two output channels: PWM, DAC code, output routing and power enables.
// Overview of operation
// - The PWM input is bits 15:4 of the channel value register, the low four bits are ignored.
// - A zero PWM input gives 50% duty, positive inputs more and negative inputs less.
// - Input 800X gives 0 of 4096 steps high and input 7FFX gives 4095 of 4096 steps high.
// - One PWM step lasts 2 us, so a full period of 4096 steps is 8.192 ms.
// - A new PWM input takes effect only when the running period ends.
// - The DAC code is the full 16-bit two's-complement channel value, zero being mid-reference.
// - With the DAC buffered to the high-drive pin, an enabled PWM drives the low-drive pin and the low-drive amplifier is off.
// - With the DAC buffered to the low-drive pin, an enabled PWM drives the high-drive pin and the high-drive amplifier is off.
// - A channel runs at most two of DAC, PWM and spare amplifier, never all three.
// - Conflicting switch requests are resolved by fixed priority, never by closing both switches.
// - Converter and amplifier power enables sit in the power register at 31h, other options in channel registers.
// - With its power enable clear a converter or amplifier is disabled with inputs and outputs high impedance.
// - A reference select picks supply or external reference, the latter doubled, for the DAC.
// - A spare amplifier in buffer mode closes feedback internally and floats its inverting pin.
// - After reset every converter and amplifier is powered off until software enables it.
`timescale 1ns/1ps
`default_nettype none
`include "dops_regs.vh"

module dops_top #(
   parameter STEP_CYCLES = `DOPS_STEP_CYCLES
) (
   input wire CLK_I,
   input wire RST_I,
   input wire [7:0] REG_ADDR_I,
   input wire [15:0] REG_WDATA_I,
   input wire REG_WE_I,
   output reg [15:0] REG_RDATA_O,
   output reg [31:0] DAC_CODE_O,
   output reg [1:0] DAC_EN_O,
   output reg [1:0] DAC_REF_EXT_O,
   output reg [1:0] HIGH_AMP_EN_O,
   output reg [1:0] HIGH_AMP_FROM_DAC_O,
   output reg [1:0] HIGH_AMP_BUF_O,
   output reg [1:0] LOW_AMP_EN_O,
   output reg [1:0] LOW_AMP_FROM_DAC_O,
   output reg [1:0] LOW_AMP_BUF_O,
   output reg [1:0] INV_PIN_HIZ_O,
   output reg [1:0] HIGH_PIN_O,
   output reg [1:0] HIGH_PIN_OE_O,
   output reg [1:0] LOW_PIN_O,
   output reg [1:0] LOW_PIN_OE_O
);

   reg [15:0] power_ff;
   reg [15:0] value_ff [0:1];
   reg [`DOPS_CFG_W-1:0] cfg_ff [0:1];
   reg [15:0] step_div_ff;
   reg step_ff;
   reg [15:0] nxt_rdata;
   wire [1:0] pwm_lvl;

   // Register writes; all enables clear at reset so nothing is powered.
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         power_ff <= `DOPS_POWER_RST;
         value_ff[0] <= `DOPS_VALUE_RST;
         value_ff[1] <= `DOPS_VALUE_RST;
         cfg_ff[0] <= `DOPS_CFG_RST;
         cfg_ff[1] <= `DOPS_CFG_RST;
      end else if (REG_WE_I) begin
         case (REG_ADDR_I)
            `DOPS_ADDR_POWER: power_ff <= REG_WDATA_I;
            `DOPS_ADDR_VALUE1: value_ff[0] <= REG_WDATA_I;
            `DOPS_ADDR_CFG1: cfg_ff[0] <= REG_WDATA_I[`DOPS_CFG_W-1:0];
            `DOPS_ADDR_VALUE2: value_ff[1] <= REG_WDATA_I;
            `DOPS_ADDR_CFG2: cfg_ff[1] <= REG_WDATA_I[`DOPS_CFG_W-1:0];
            default: power_ff <= power_ff;
         endcase
      end
   end

   // Step divider: one enable pulse per 2 us step, shared by both channels so
   // their periods stay aligned.
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         step_div_ff <= 16'h0000;
         step_ff <= 1'b0;
      end else if (step_div_ff == STEP_CYCLES[15:0] - 16'h0001) begin
         step_div_ff <= 16'h0000;
         step_ff <= 1'b1;
      end else begin
         step_div_ff <= step_div_ff + 16'h0001;
         step_ff <= 1'b0;
      end
   end

   // Readback; unmapped addresses read zero. Status shows live PWM levels.
   always @* begin
      case (REG_ADDR_I)
         `DOPS_ADDR_POWER: nxt_rdata = power_ff;
         `DOPS_ADDR_VALUE1: nxt_rdata = value_ff[0];
         `DOPS_ADDR_CFG1: nxt_rdata = {{(16-`DOPS_CFG_W){1'b0}}, cfg_ff[0]};
         `DOPS_ADDR_VALUE2: nxt_rdata = value_ff[1];
         `DOPS_ADDR_CFG2: nxt_rdata = {{(16-`DOPS_CFG_W){1'b0}}, cfg_ff[1]};
         `DOPS_ADDR_STATUS: nxt_rdata = {14'h0000, pwm_lvl};
         default: nxt_rdata = 16'h0000;
      endcase
   end

   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         REG_RDATA_O <= 16'h0000;
      end else begin
         REG_RDATA_O <= nxt_rdata;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         wire conv_pwr;
         wire amp_pwr;
         wire dac_on;
         wire dac_high;
         wire pwm_on;
         wire spare_on;
         wire spare_buf;
         wire hi_dac;
         wire lo_dac;
         wire hi_spare;
         wire lo_spare;

         assign conv_pwr = power_ff[ch*`DOPS_PWR_STRIDE + `DOPS_PWR_CONV_BIT];
         assign amp_pwr = power_ff[ch*`DOPS_PWR_STRIDE + `DOPS_PWR_AMP_BIT];
         // The DAC path needs both the converter and its buffer amplifier powered.
         assign dac_on = cfg_ff[ch][`DOPS_CFG_DAC_EN] & conv_pwr & amp_pwr;
         assign dac_high = cfg_ff[ch][`DOPS_CFG_DAC_HIGH];
         assign pwm_on = cfg_ff[ch][`DOPS_CFG_PWM_EN];
         // PWM owns the spare-side pin ahead of the spare amplifier, so the
         // three functions can never all be live on two pins.
         assign spare_on = cfg_ff[ch][`DOPS_CFG_SPARE_EN] & amp_pwr & ~pwm_on;
         assign spare_buf = cfg_ff[ch][`DOPS_CFG_SPARE_BUF];
         assign hi_dac = dac_on & dac_high;
         assign lo_dac = dac_on & ~dac_high;
         assign hi_spare = spare_on & ~dac_high;
         assign lo_spare = spare_on & dac_high;

         dops_pwm u_pwm (
            .clk_i(CLK_I),
            .rst_i(RST_I),
            .step_i(step_ff),
            .value_i(value_ff[ch][`DOPS_PWM_MSB:`DOPS_PWM_LSB]),
            .pwm_o(pwm_lvl[ch])
         );

         // Analog switch controls and pin drive, registered so the switches move
         // together on one edge.
         always @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
               DAC_CODE_O[ch*16 +: 16] <= 16'h0000;
               DAC_EN_O[ch] <= 1'b0;
               DAC_REF_EXT_O[ch] <= 1'b0;
               HIGH_AMP_EN_O[ch] <= 1'b0;
               HIGH_AMP_FROM_DAC_O[ch] <= 1'b0;
               HIGH_AMP_BUF_O[ch] <= 1'b0;
               LOW_AMP_EN_O[ch] <= 1'b0;
               LOW_AMP_FROM_DAC_O[ch] <= 1'b0;
               LOW_AMP_BUF_O[ch] <= 1'b0;
               INV_PIN_HIZ_O[ch] <= 1'b1;
               HIGH_PIN_O[ch] <= 1'b0;
               HIGH_PIN_OE_O[ch] <= 1'b0;
               LOW_PIN_O[ch] <= 1'b0;
               LOW_PIN_OE_O[ch] <= 1'b0;
            end else begin
               DAC_CODE_O[ch*16 +: 16] <= value_ff[ch];
               DAC_EN_O[ch] <= dac_on;
               DAC_REF_EXT_O[ch] <= cfg_ff[ch][`DOPS_CFG_REF_EXT];
               HIGH_AMP_EN_O[ch] <= hi_dac | hi_spare;
               HIGH_AMP_FROM_DAC_O[ch] <= hi_dac;
               // A DAC buffer is always unity gain.
               HIGH_AMP_BUF_O[ch] <= hi_dac | (hi_spare & spare_buf);
               LOW_AMP_EN_O[ch] <= lo_dac | lo_spare;
               LOW_AMP_FROM_DAC_O[ch] <= lo_dac;
               LOW_AMP_BUF_O[ch] <= lo_dac | (lo_spare & spare_buf);
               // Inverting pin floats unless a stand-alone spare amp uses it.
               INV_PIN_HIZ_O[ch] <= ~(spare_on & ~spare_buf);
               HIGH_PIN_O[ch] <= pwm_on & ~dac_high & pwm_lvl[ch];
               HIGH_PIN_OE_O[ch] <= pwm_on & ~dac_high;
               LOW_PIN_O[ch] <= pwm_on & dac_high & pwm_lvl[ch];
               LOW_PIN_OE_O[ch] <= pwm_on & dac_high;
            end
         end
      end
   endgenerate

endmodule // dops_top

`default_nettype wire

// ---- inc/dops_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the output channels.
`ifndef DOPS_REGS_VH
`define DOPS_REGS_VH

// Register addresses on the module register port.
`define DOPS_ADDR_POWER 8'h31
`define DOPS_ADDR_VALUE1 8'h38
`define DOPS_ADDR_CFG1 8'h39
`define DOPS_ADDR_VALUE2 8'h3A
`define DOPS_ADDR_CFG2 8'h3B
`define DOPS_ADDR_STATUS 8'h3C

// Power enable fields, two bits per channel: converter, then amplifiers.
`define DOPS_PWR_CONV_BIT 0
`define DOPS_PWR_AMP_BIT 1
`define DOPS_PWR_STRIDE 2

// Channel configuration fields.
`define DOPS_CFG_DAC_EN 0
`define DOPS_CFG_PWM_EN 1
`define DOPS_CFG_DAC_HIGH 2
`define DOPS_CFG_SPARE_EN 3
`define DOPS_CFG_SPARE_BUF 4
`define DOPS_CFG_REF_EXT 5
`define DOPS_CFG_W 6

// Reset values: everything powered off and idle.
`define DOPS_POWER_RST 16'h0000
`define DOPS_VALUE_RST 16'h0000
`define DOPS_CFG_RST 6'h00

// Timing: one PWM step lasts 2 us; clock period 4 ns.
`define DOPS_STEP_NS 2000
`define DOPS_CLK_NS 4
`define DOPS_STEP_CYCLES ((`DOPS_STEP_NS + `DOPS_CLK_NS - 1) / `DOPS_CLK_NS)

// PWM geometry: 12-bit steps, input taken from bits 15:4 of the value.
`define DOPS_PWM_W 12
`define DOPS_PWM_MSB 15
`define DOPS_PWM_LSB 4

`endif

// ---- design/dops_pwm.v ----
// Twelve-bit PWM generator with end-of-period input update.
`timescale 1ns/1ps
`default_nettype none
`include "dops_regs.vh"

module dops_pwm #(
   parameter PWM_W = `DOPS_PWM_W
) (
   input wire clk_i,
   input wire rst_i,
   input wire step_i,
   input wire [PWM_W-1:0] value_i,
   output wire pwm_o
);

   reg [PWM_W-1:0] step_cnt_ff;
   reg [PWM_W-1:0] active_ff;
   wire period_end;
   wire [PWM_W-1:0] threshold;

   assign period_end = step_i & (&step_cnt_ff);
   // Inverting the sign bit turns two's complement into value plus half scale.
   assign threshold = {~active_ff[PWM_W-1], active_ff[PWM_W-2:0]};
   // High while the step count is below value plus half scale.
   assign pwm_o = (step_cnt_ff < threshold);

   // Free-running step counter; the input is only sampled at the period end so a
   // write mid-period can never shorten or stretch the pulse in flight.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_cnt_ff <= {PWM_W{1'b0}};
         active_ff <= {PWM_W{1'b0}};
      end else begin
         if (step_i) begin
            step_cnt_ff <= step_cnt_ff + 1'b1;
         end
         if (period_end) begin
            active_ff <= value_i;
         end
      end
   end

endmodule // dops_pwm

`default_nettype wire

// ---- dv/dops_props.sv ----
// Concurrent checks on the ports of the two output channel controller.
`timescale 1ns/1ps
`default_nettype none
`include "dops_regs.vh"
module dops_props #(
   parameter STEP_CYCLES = 500
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic REG_WE_I,
   input wire logic [31:0] DAC_CODE_O,
   input wire logic [1:0] DAC_EN_O,
   input wire logic [1:0] HIGH_AMP_EN_O,
   input wire logic [1:0] HIGH_AMP_FROM_DAC_O,
   input wire logic [1:0] HIGH_AMP_BUF_O,
   input wire logic [1:0] LOW_AMP_EN_O,
   input wire logic [1:0] LOW_AMP_FROM_DAC_O,
   input wire logic [1:0] LOW_AMP_BUF_O,
   input wire logic [1:0] INV_PIN_HIZ_O,
   input wire logic [1:0] HIGH_PIN_OE_O,
   input wire logic [1:0] LOW_PIN_OE_O
);
   // All checks share the system clock; all but reset_off_a are quiet while reset is applied.
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // The first reset edge is where the flops take their reset, so it is skipped.
   reset_off_a: assert property (disable iff (1'b0)
      RST_I ##1 RST_I |-> (DAC_EN_O | HIGH_AMP_EN_O | LOW_AMP_EN_O) == 2'b00
      && INV_PIN_HIZ_O == 2'b11)
      else $error("Channel outputs active during reset.");
   hi_pin_excl_a: assert property ((HIGH_PIN_OE_O & HIGH_AMP_EN_O) == 2'b00)
      else $error("High-drive pin driven by PWM and amplifier.");
   lo_pin_excl_a: assert property ((LOW_PIN_OE_O & LOW_AMP_EN_O) == 2'b00)
      else $error("Low-drive pin driven by PWM and amplifier.");
   three_func_a: assert property ((DAC_EN_O & (HIGH_PIN_OE_O | LOW_PIN_OE_O) &
      ((HIGH_AMP_EN_O & ~HIGH_AMP_FROM_DAC_O) |
      (LOW_AMP_EN_O & ~LOW_AMP_FROM_DAC_O))) == 2'b00)
      else $error("Three functions on two pins.");
   dac_path_a: assert property ((DAC_EN_O & ~((HIGH_AMP_EN_O & HIGH_AMP_FROM_DAC_O) |
      (LOW_AMP_EN_O & LOW_AMP_FROM_DAC_O))) == 2'b00) else $error("DAC on without buffer.");
   spare_hiz_a: assert property ((((HIGH_AMP_EN_O & ~HIGH_AMP_FROM_DAC_O & HIGH_AMP_BUF_O) |
      (LOW_AMP_EN_O & ~LOW_AMP_FROM_DAC_O & LOW_AMP_BUF_O)) & ~INV_PIN_HIZ_O) == 2'b00)
      else $error("Buffered spare amplifier drives its inverting pin.");
   dac_code_a: assert property (REG_WE_I && REG_ADDR_I == `DOPS_ADDR_VALUE1
      ##1 !REG_WE_I [*2] |=> DAC_CODE_O[15:0] == $past(REG_WDATA_I, 3))
      else $error("DAC code does not follow the value register.");
   en_cause_a: assert property ($changed(DAC_EN_O)
      |-> $past(REG_WE_I) || $past(REG_WE_I, 2) || $past(REG_WE_I, 3))
      else $error("DAC enable changed without a register write.");
endmodule // dops_props
bind dops_top dops_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (.CLK_I(CLK_I), .RST_I(RST_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I),
   .DAC_CODE_O(DAC_CODE_O), .DAC_EN_O(DAC_EN_O), .HIGH_AMP_EN_O(HIGH_AMP_EN_O),
   .HIGH_AMP_FROM_DAC_O(HIGH_AMP_FROM_DAC_O), .HIGH_AMP_BUF_O(HIGH_AMP_BUF_O),
   .LOW_AMP_EN_O(LOW_AMP_EN_O), .LOW_AMP_FROM_DAC_O(LOW_AMP_FROM_DAC_O),
   .LOW_AMP_BUF_O(LOW_AMP_BUF_O), .INV_PIN_HIZ_O(INV_PIN_HIZ_O),
   .HIGH_PIN_OE_O(HIGH_PIN_OE_O), .LOW_PIN_OE_O(LOW_PIN_OE_O));
`default_nettype wire

// ---- dv/dops_load.sv ----
// Load model of one pin pair: shows the level each output pin really presents.
`timescale 1ns/1ps
`default_nettype none
module dops_load (
   input wire logic clk_i,
   input wire logic [1:0] pin_i,
   input wire logic [1:0] oe_i,
   output logic [1:0] level_o
);
   // The pins have no pull, so a released pin toggles instead of keeping a stale level.
   logic [1:0] flip_ff = 2'b01;
   always @(posedge clk_i) begin
      flip_ff <= ~flip_ff;
   end
   assign level_o = (oe_i & pin_i) | (~oe_i & flip_ff);
endmodule // dops_load
`default_nettype wire

// ---- dv/test_dual_output_dac_pwm_select.sv ----
// Self-checking bench for the two output channel controller.
`timescale 1ns/1ps
`default_nettype none
`include "dops_regs.vh"
module test_dual_output_dac_pwm_select;
   localparam int STEP = 2;
   localparam int PER = 4096 * STEP;
   localparam logic [7:0] CASES [5] = '{8'hC7, 8'hE3, 8'hDD, 8'hCF, 8'h41};
   logic clk = 0, rst = 1, we = 0;
   logic [7:0] addr = 8'h00, s;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [31:0] code, hi, lo, rnd = 32'hbac7_cdfe;
   logic [1:0] dac_en, ref_ext, h_en, h_dac, h_buf, l_en, l_dac, l_buf, hiz;
   logic [1:0] h_pin, h_oe, l_pin, l_oe, h_lvl, l_lvl;
   int bad_count = 0, n_tests = 0;
   dops_top #(.STEP_CYCLES(STEP)) uut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RDATA_O(rdata), .DAC_CODE_O(code),
      .DAC_EN_O(dac_en), .DAC_REF_EXT_O(ref_ext), .HIGH_AMP_EN_O(h_en),
      .HIGH_AMP_FROM_DAC_O(h_dac), .HIGH_AMP_BUF_O(h_buf), .LOW_AMP_EN_O(l_en),
      .LOW_AMP_FROM_DAC_O(l_dac), .LOW_AMP_BUF_O(l_buf), .INV_PIN_HIZ_O(hiz),
      .HIGH_PIN_O(h_pin), .HIGH_PIN_OE_O(h_oe), .LOW_PIN_O(l_pin), .LOW_PIN_OE_O(l_oe));
   dops_load hload (.clk_i(clk), .pin_i(h_pin), .oe_i(h_oe), .level_o(h_lvl));
   dops_load lload (.clk_i(clk), .pin_i(l_pin), .oe_i(l_oe), .level_o(l_lvl));
   // Free-running system clock.
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected {dac, high amp, low amp, high pin, low pin, inverting hiz} for {power, cfg}.
   function automatic logic [5:0] exp_route(input logic [7:0] c);
      logic dac, sp;
      dac = c[0] & c[6] & c[7];
      sp = c[3] & ~c[1] & c[7];
      return {dac, c[2] ? dac : sp, c[2] ? sp : dac, c[1] & ~c[2], c[1] & c[2], ~(sp & ~c[4])};
   endfunction
   // Expected {high from dac, low from dac, high buffer, low buffer}; a DAC buffer is unity gain.
   function automatic logic [3:0] exp_amp(input logic [7:0] c);
      logic dac, sp;
      dac = c[0] & c[6] & c[7];
      sp = c[3] & ~c[1] & c[7];
      return {dac & c[2], dac & ~c[2], (dac & c[2]) | (sp & ~c[2] & c[4]),
         (dac & ~c[2]) | (sp & c[2] & c[4])};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      we = 1;
      addr = a;
      wdata = d;
      @(negedge clk);
      we = 0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clk);
      addr = a;
      repeat (2) @(negedge clk);
      check(rdata, exp);
   endtask
   // Counts high cycles over one whole period, which is independent of phase.
   task automatic duty(input logic [15:0] val);
      wr(`DOPS_ADDR_VALUE2, ~val);
      wr(`DOPS_ADDR_VALUE1, val);
      repeat (PER + 8) @(negedge clk);
      check(code, {~val, val});
      hi = 0;
      lo = 0;
      repeat (PER) begin
         @(negedge clk);
         hi += h_lvl[0];
         lo += l_lvl[1];
      end
      check(hi, STEP * (val[15:4] ^ 12'h800));
      check(lo, STEP * (4095 - (val[15:4] ^ 12'h800)));
   endtask
   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short: the whole sequence needs well under this many clocks.
   initial begin
      #(100000 * 4);
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(negedge clk);
      rst = 0;
      check({dac_en, h_en, l_en, hiz}, 8'h03);
      rdchk(`DOPS_ADDR_POWER, 16'h0000);
      wr(8'h50, 16'hFFFF);
      rdchk(8'h50, 16'h0000);
      rdchk(`DOPS_ADDR_CFG1, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 13; i++) begin
         rnd = lfsr(rnd);
         s = (i < 5) ? CASES[i] : rnd[7:0];
         wr(`DOPS_ADDR_CFG1, {10'h000, s[5:0]});
         wr(`DOPS_ADDR_CFG2, {10'h000, s[5:0]});
         wr(`DOPS_ADDR_POWER, {12'h000, s[7:6], s[7:6]});
         repeat (3) @(negedge clk);
         for (int j = 0; j < 2; j++) begin
            check({dac_en[j], h_en[j], l_en[j], h_oe[j], l_oe[j], hiz[j]}, exp_route(s));
            check({h_dac[j], l_dac[j], h_buf[j], l_buf[j]}, exp_amp(s));
            if (exp_route(s) >= 6'h20) check(ref_ext[j], s[5]);
         end
         rdchk(`DOPS_ADDR_CFG2, {10'h000, s[5:0]});
      end
      $display("test routing done");
      wr(`DOPS_ADDR_POWER, 16'h0000);
      wr(`DOPS_ADDR_CFG1, 16'h0002);
      // Channel two runs its PWM on the low-drive pin, so both pins are counted.
      wr(`DOPS_ADDR_CFG2, 16'h0006);
      duty(16'h000A);
      while (h_lvl[0] !== 1'b1) @(negedge clk);
      while (h_lvl[0] !== 1'b0) @(negedge clk);
      wr(`DOPS_ADDR_VALUE1, 16'h7FF5);
      hi = 0;
      repeat (4000) begin
         @(negedge clk);
         hi += h_lvl[0];
      end
      check(hi, 0);
      duty(16'h7FF5);
      duty(16'h800F);
      rnd = lfsr(rnd);
      duty(rnd[15:0]);
      $display("test pwm done");
      report_and_stop();
   end
endmodule // test_dual_output_dac_pwm_select
`default_nettype wire
